// ---- verilog/nvtr_defs.vh ----
// constants for the nested virtualisation trap and redirect block
// included by every design file of the block; definitions only
`ifndef NVTR_DEFS_VH
`define NVTR_DEFS_VH

// apb byte offsets
`define NVTR_CTRL_OFF    8'h00
`define NVTR_CFG_OFF     8'h04
`define NVTR_STAT_OFF    8'h08
`define NVTR_CLR_OFF     8'h0c
`define NVTR_EN_OFF      8'h10
`define NVTR_LAST_OFF    8'h14
`define NVTR_CNT_OFF     8'h18
`define NVTR_INFO_OFF    8'h1c

// field positions
`define NVTR_NV_CFG_POS  42
`define NVTR_NV_BIT      10
`define NVTR_NV2_BIT     0
`define NVTR_TSC_BIT     1
`define NVTR_API_BIT     2

// reset values
`define NVTR_CTRL_RST    3'h0
`define NVTR_EN_RST      3'h0

// syndrome classes
`define NVTR_EC_SYSREG   6'h18
`define NVTR_EC_SMC      6'h17
`define NVTR_EC_ERET     6'h1a
`define NVTR_EC_PAUTH    6'h09
`define NVTR_FAKE_LEVEL  2'h2

// operation kinds
`define NVTR_OP_NONE     4'h0
`define NVTR_OP_RD       4'h1
`define NVTR_OP_WR       4'h2
`define NVTR_OP_CUR_RD   4'h3
`define NVTR_OP_AT_HYP   4'h4
`define NVTR_OP_AT_KERN  4'h5
`define NVTR_OP_SMC      4'h6
`define NVTR_OP_ERET     4'h7
`define NVTR_OP_ERETAA   4'h8
`define NVTR_OP_ERETAB   4'h9

// register classes
`define NVTR_R_OTHER     4'h0
`define NVTR_R_HYP       4'h1
`define NVTR_R_HYP_K     4'h2
`define NVTR_R_HYP_U     4'h3
`define NVTR_R_SP_HYP    4'h4
`define NVTR_R_BANKED    4'h5
`define NVTR_R_SP_KERN   4'h6
`define NVTR_R_SS_HYP    4'h7
`define NVTR_R_ERA_HYP   4'h8
`define NVTR_R_SYN_HYP   4'h9
`define NVTR_R_FA_HYP    4'ha
`define NVTR_R_SS_KERN   4'hb
`define NVTR_R_ERA_KERN  4'hc
`define NVTR_R_SYN_KERN  4'hd
`define NVTR_R_FA_KERN   4'he

// interrupt status bits
`define NVTR_IRQ_N       3
`define NVTR_S_TRAP      0
`define NVTR_S_REDIR     1
`define NVTR_S_PRIO      2
`endif

// ---- verilog/nvtr_classify.v ----
// combinational classifier: decides trap, syndrome and redirect per op
// assumes a same-clock op descriptor; the caller registers the results
`timescale 1ns/1ps
`include "nvtr_defs.vh"
module nvtr_classify #(
   parameter HAS_MONITOR = 0
) (
   // mode
   input  wire       trap_mode,
   input  wire       redir_mode,
   input  wire       smc_trap_ctrl,
   input  wire       hyp_en,
   // op
   input  wire       op_valid,
   input  wire [1:0] op_level,
   input  wire [3:0] op_kind,
   input  wire [3:0] op_reg,
   input  wire       pauth_req,
   // result
   output reg        trap,
   output reg  [5:0] ec,
   output reg        redir,
   output reg  [3:0] redir_reg,
   output reg  [1:0] level_data,
   output reg        prio_hit
);

   // hyp, hyp-kernel, hyp-user suffix classes and the ss/era/syn/fa hyp classes, stack_ptr_hyp excluded
   function is_hyp;
      input [3:0] r;
      begin
         is_hyp = (r == `NVTR_R_HYP) || (r == `NVTR_R_HYP_K) ||
                  (r == `NVTR_R_HYP_U) || (r >= `NVTR_R_SS_HYP && r <= `NVTR_R_FA_HYP);
      end
   endfunction

   reg gate;
   reg acc;
   reg t_reg;
   reg t_at;
   reg t_smc;
   reg t_eret;
   reg auth;

   // trap and redirect decision
   always @* begin
      gate   = op_valid && (op_level == 2'h1) && hyp_en;
      acc    = (op_kind == `NVTR_OP_RD) || (op_kind == `NVTR_OP_WR);
      t_reg  = acc && (is_hyp(op_reg) || op_reg == `NVTR_R_BANKED ||
                       op_reg == `NVTR_R_SP_KERN);
      t_at   = (op_kind == `NVTR_OP_AT_HYP) || (op_kind == `NVTR_OP_AT_KERN);
      t_smc  = (op_kind == `NVTR_OP_SMC) && (HAS_MONITOR == 0) && smc_trap_ctrl;
      auth   = (op_kind == `NVTR_OP_ERETAA) || (op_kind == `NVTR_OP_ERETAB);
      t_eret = (op_kind == `NVTR_OP_ERET) || auth;
      trap     = 1'b0;
      ec       = `NVTR_EC_SYSREG;
      prio_hit = 1'b0;
      if (gate && trap_mode && (t_reg || t_at || t_smc || t_eret)) begin
         trap = 1'b1;
         if (t_smc)
            ec = `NVTR_EC_SMC;
         else if (t_eret)
            ec = `NVTR_EC_ERET;
         prio_hit = auth && pauth_req;
      end else if (gate && auth && pauth_req) begin
         trap = 1'b1;
         ec   = `NVTR_EC_PAUTH;
      end
      redir     = op_valid && redir_mode && acc && (op_level == 2'h1) &&
                  (op_reg >= `NVTR_R_SS_HYP) && (op_reg <= `NVTR_R_FA_HYP);
      redir_reg = op_reg;
      case (op_reg)
         `NVTR_R_SS_HYP:  if (redir) redir_reg = `NVTR_R_SS_KERN;
         `NVTR_R_ERA_HYP: if (redir) redir_reg = `NVTR_R_ERA_KERN;
         `NVTR_R_SYN_HYP: if (redir) redir_reg = `NVTR_R_SYN_KERN;
         `NVTR_R_FA_HYP:  if (redir) redir_reg = `NVTR_R_FA_KERN;
         default:         redir_reg = op_reg;
      endcase
      // faked level readback
      level_data = (gate && trap_mode) ? `NVTR_FAKE_LEVEL : op_level;
   end

endmodule // nvtr_classify

// ---- verilog/nvtr_irq.v ----
// sticky event status, write-one-to-clear, enable mask, level interrupt
// assumes single-cycle event pulses from the same clock domain
`timescale 1ns/1ps
`include "nvtr_defs.vh"
module nvtr_irq #(
   parameter N = 3
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // events and control
   input  wire [N-1:0] ev,
   input  wire         clr_wr,
   input  wire [N-1:0] clr_data,
   input  wire [N-1:0] en,
   // result
   output wire [N-1:0] status,
   output reg          irq
);

   reg [N-1:0] status_reg;
   genvar i;

   // per-bit sticky flag; a set in the clear cycle wins
   generate
      for (i = 0; i < N; i = i + 1) begin : g_bit
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               status_reg[i] <= 1'b0;
            else if (ev[i])
               status_reg[i] <= 1'b1;
            else if (clr_wr && clr_data[i])
               status_reg[i] <= 1'b0;
         end
      end
   endgenerate

   assign status = status_reg;

   // registered level interrupt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(status_reg & en);
   end

endmodule // nvtr_irq

// ---- verilog/nvtr_top.v ----
// nested virtualisation trap and redirect control with apb registers
// assumes op descriptors from pipeline logic on pclk, apb master on pclk
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "nvtr_defs.vh"

module nvtr_top #(
   parameter NESTED_VIRT_FEATURE     = 1,
   parameter NESTED_VIRT_V2_FEATURE    = 1,
   parameter HAS_MONITOR = 0,
   parameter CNT_W       = 16
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // op descriptor from the pipeline
   input  wire        op_valid,
   input  wire [1:0]  op_level,
   input  wire [3:0]  op_kind,
   input  wire [3:0]  op_reg,
   input  wire        hyp_en,
   input  wire        pauth_req,
   // trap and redirect result
   output reg         trap_valid,
   output reg  [5:0]  trap_ec,
   output reg         redir_valid,
   output reg  [3:0]  redir_reg,
   output reg         level_valid,
   output reg  [1:0]  level_data,
   // tlb and interrupt
   output reg         nv_tlb,
   output wire        irq
);

   localparam HAS_NV  = (NESTED_VIRT_FEATURE != 0) || (NESTED_VIRT_V2_FEATURE != 0);
   localparam HAS_NV2 = (NESTED_VIRT_V2_FEATURE != 0);
   localparam HAS_TSC = HAS_NV && (HAS_MONITOR == 0);

   // control state
   reg              nv_reg;
   reg              nv2_reg;
   reg              tsc_reg;
   reg              api_reg;
   reg [`NVTR_IRQ_N-1:0] en_reg;
   reg [6:0]        last_reg;
   reg [CNT_W-1:0]  cnt_reg;
   reg [CNT_W-1:0]  cnt_next;

   // apb decode
   wire             acc_ph;
   wire             wr_en;
   wire             rd_en;
   reg              hit;
   reg [31:0]       rdata_next;

   // mode and classifier results
   wire             redir_mode;
   wire             trap_mode;
   wire             c_trap;
   wire [5:0]       c_ec;
   wire             c_redir;
   wire [3:0]       c_redir_reg;
   wire [1:0]       c_level;
   wire             c_prio;
   wire [`NVTR_IRQ_N-1:0] ev;
   wire [`NVTR_IRQ_N-1:0] status;
   wire             clr_wr;

   // access phase with one wait state; pready rises on the second cycle
   assign acc_ph = psel && penable;
   assign wr_en  = acc_ph && pready && pwrite;
   assign rd_en  = acc_ph && !pready && !pwrite;

   // effective modes: redirect needs enable, trap needs redirect clear
   assign redir_mode = HAS_NV2 && nv_reg && nv2_reg;
   assign trap_mode  = HAS_NV && nv_reg && !redir_mode;

   nvtr_classify #(
      .HAS_MONITOR (HAS_MONITOR)
   ) u_classify (
      .trap_mode  (trap_mode),
      .redir_mode (redir_mode),
      .smc_trap_ctrl        (tsc_reg),
      .hyp_en     (hyp_en),
      .op_valid   (op_valid),
      .op_level   (op_level),
      .op_kind    (op_kind),
      .op_reg     (op_reg),
      .pauth_req  (pauth_req && !api_reg),
      .trap       (c_trap),
      .ec         (c_ec),
      .redir      (c_redir),
      .redir_reg  (c_redir_reg),
      .level_data (c_level),
      .prio_hit   (c_prio)
   );

   // event pulses into the sticky status
   assign ev[`NVTR_S_TRAP]  = c_trap;
   assign ev[`NVTR_S_REDIR] = c_redir;
   assign ev[`NVTR_S_PRIO]  = c_prio;
   assign clr_wr = wr_en && (paddr == `NVTR_CLR_OFF);

   nvtr_irq #(
      .N (`NVTR_IRQ_N)
   ) u_irq (
      .pclk     (pclk),
      .presetn  (presetn),
      .ev       (ev),
      .clr_wr   (clr_wr),
      .clr_data (pwdata[`NVTR_IRQ_N-1:0]),
      .en       (en_reg),
      .status   (status),
      .irq      (irq)
   );

   // read mux and address hit
   always @* begin
      hit        = 1'b1;
      rdata_next = 32'h0000_0000;
      case (paddr)
         `NVTR_CTRL_OFF: begin
            rdata_next[`NVTR_NV2_BIT] = nv2_reg;
            rdata_next[`NVTR_TSC_BIT] = tsc_reg;
            rdata_next[`NVTR_API_BIT] = api_reg;
         end
         `NVTR_CFG_OFF: begin
            rdata_next[`NVTR_NV_BIT] = nv_reg;
         end
         `NVTR_STAT_OFF: begin
            rdata_next[`NVTR_IRQ_N-1:0] = status;
         end
         `NVTR_CLR_OFF: begin
            rdata_next = 32'h0000_0000;
         end
         `NVTR_EN_OFF: begin
            rdata_next[`NVTR_IRQ_N-1:0] = en_reg;
         end
         `NVTR_LAST_OFF: begin
            rdata_next[6:0] = last_reg;
         end
         `NVTR_CNT_OFF: begin
            rdata_next[CNT_W-1:0] = cnt_reg;
         end
         `NVTR_INFO_OFF: begin
            rdata_next[0] = HAS_NV;
            rdata_next[1] = HAS_NV2;
            rdata_next[2] = (HAS_MONITOR != 0);
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // apb handshake and answer, all from flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc_ph && !pready;
         pslverr <= acc_ph && !pready && !hit;
         if (rd_en)
            prdata <= rdata_next;
      end
   end

   // software control bits; absent features stay zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nv_reg  <= 1'b0;
         nv2_reg <= 1'b0;
         tsc_reg <= 1'b0;
         api_reg <= 1'b0;
         en_reg  <= `NVTR_EN_RST;
      end else if (wr_en) begin
         if (paddr == `NVTR_CFG_OFF)
            nv_reg <= HAS_NV && pwdata[`NVTR_NV_BIT];
         if (paddr == `NVTR_CTRL_OFF) begin
            nv2_reg <= HAS_NV2 && pwdata[`NVTR_NV2_BIT];
            tsc_reg <= HAS_TSC && pwdata[`NVTR_TSC_BIT];
            api_reg <= pwdata[`NVTR_API_BIT];
         end
         if (paddr == `NVTR_EN_OFF)
            en_reg <= pwdata[`NVTR_IRQ_N-1:0];
      end
   end

   // saturating trap counter
   always @* begin
      cnt_next = cnt_reg;
      if (wr_en && paddr == `NVTR_CNT_OFF)
         cnt_next = {CNT_W{1'b0}};
      if (c_trap && !(&cnt_reg))
         cnt_next = cnt_reg + 1'b1;
   end

   // last syndrome taken, bit 6 marks it valid
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_reg <= 7'h00;
         cnt_reg  <= {CNT_W{1'b0}};
      end else begin
         cnt_reg <= cnt_next;
         if (c_trap)
            last_reg <= {1'b1, c_ec};
      end
   end

   // registered results to the pipeline, one cycle after the op
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_valid  <= 1'b0;
         trap_ec     <= 6'h00;
         redir_valid <= 1'b0;
         redir_reg   <= 4'h0;
         level_valid <= 1'b0;
         level_data  <= 2'h0;
         nv_tlb      <= 1'b0;
      end else begin
         trap_valid  <= c_trap;
         trap_ec     <= c_trap ? c_ec : 6'h00;
         redir_valid <= c_redir;
         redir_reg   <= c_redir_reg;
         level_valid <= op_valid && (op_kind == `NVTR_OP_CUR_RD);
         level_data  <= c_level;
         nv_tlb      <= nv_reg;
      end
   end

endmodule // nvtr_top

// ---- bench/nvtr_top_chk.sv ----
// concurrent checks on the ports of the trap and redirect block
// bound into nvtr_top; one clock pclk, asynchronous low reset presetn
`timescale 1ns/1ps
`include "nvtr_defs.vh"
module nvtr_top_chk (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   // op descriptor
   input wire        op_valid,
   input wire [1:0]  op_level,
   input wire [3:0]  op_kind,
   input wire [3:0]  op_reg,
   input wire        hyp_en,
   input wire        pauth_req,
   // results
   input wire        trap_valid,
   input wire [5:0]  trap_ec,
   input wire        redir_valid,
   input wire [3:0]  redir_reg,
   input wire        level_valid,
   input wire [1:0]  level_data
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // apb phases and plain (non pointer-auth) ops
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable; endsequence
   wire plain = op_valid && !pauth_req;

   a_apb_wait: assert property (setup_s ##1 access_s |=> pready)
      else $error("apb answer not after one wait state");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   a_ec_idle: assert property (!trap_valid |-> trap_ec == 6'h00)
      else $error("syndrome without trap");
   a_hyp_quiet: assert property (plain && op_level == 2'h2 |=> !trap_valid)
      else $error("trap of a hyp level op");
   a_nohyp_quiet: assert property (plain && !hyp_en |=> !trap_valid)
      else $error("trap while hyp level disabled");
   a_sysreg_class: assert property (
      plain && (op_kind == `NVTR_OP_RD || op_kind == `NVTR_OP_WR
      || op_kind == `NVTR_OP_AT_HYP || op_kind == `NVTR_OP_AT_KERN)
      |=> !trap_valid || trap_ec == `NVTR_EC_SYSREG)
      else $error("wrong class for register or tlb trap");
   a_smc_class: assert property (plain && op_kind == `NVTR_OP_SMC
      |=> !trap_valid || trap_ec == `NVTR_EC_SMC)
      else $error("wrong class for monitor call trap");
   a_eret_class: assert property (op_valid && op_kind >= `NVTR_OP_ERET
      |=> !trap_valid || trap_ec == `NVTR_EC_ERET || trap_ec == `NVTR_EC_PAUTH)
      else $error("wrong class for return trap");
   a_level_answer: assert property (op_valid && op_kind == `NVTR_OP_CUR_RD
      |=> level_valid
      && (level_data == `NVTR_FAKE_LEVEL || level_data == $past(op_level)))
      else $error("bad current level answer");
   a_redir_target: assert property (redir_valid |-> redir_reg >= 4'hb && redir_reg <= 4'he)
      else $error("redirect to a non kernel register");
   a_redir_source: assert property (op_valid && (op_level != 2'h1 || op_reg < 4'h7
      || op_reg > 4'ha) |=> !redir_valid)
      else $error("redirect of a register without a kernel copy");
endmodule // nvtr_top_chk

bind nvtr_top nvtr_top_chk u_nvtr_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
   .op_level(op_level), .op_kind(op_kind), .op_reg(op_reg), .hyp_en(hyp_en),
   .pauth_req(pauth_req), .trap_valid(trap_valid), .trap_ec(trap_ec),
   .redir_valid(redir_valid), .redir_reg(redir_reg), .level_valid(level_valid),
   .level_data(level_data));

// ---- bench/nested_virt_trap_redirect_bench.sv ----
// self-checking bench for the trap and redirect block
// drives apb and the op port itself; expectations from bench functions
`timescale 1ns/1ps
`include "nvtr_defs.vh"
module nested_virt_trap_redirect_bench;
   reg         pclk, presetn, psel, penable, pwrite, op_valid, hyp_en, pauth_req;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, rdata, seed;
   reg  [1:0]  op_level, rl;
   reg  [3:0]  op_kind, op_reg, rk;
   reg         nv, rd, smc_trap_ctrl, pa, err, rh;
   wire [31:0] prdata;
   wire [5:0]  trap_ec;
   wire [3:0]  redir_reg;
   wire [1:0]  level_data;
   wire        pready, pslverr, trap_valid, redir_valid, level_valid, nv_tlb, irq;
   integer     failures, checked, m, i;

   nvtr_top #(.NESTED_VIRT_FEATURE(1), .NESTED_VIRT_V2_FEATURE(1), .HAS_MONITOR(0), .CNT_W(16)) u_nvtr_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .op_valid(op_valid), .op_level(op_level), .op_kind(op_kind), .op_reg(op_reg),
      .hyp_en(hyp_en), .pauth_req(pauth_req), .trap_valid(trap_valid), .trap_ec(trap_ec),
      .redir_valid(redir_valid), .redir_reg(redir_reg), .level_valid(level_valid),
      .level_data(level_data), .nv_tlb(nv_tlb), .irq(irq));

   // compare and count
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task apb(input wr, input [7:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         // no cycle limit here; the watchdog ends a hung access
         do
            @(posedge pclk);
         while (pready !== 1'b1);
         rdata = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rd_chk(input [7:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0000_0000);
         check(rdata, exp);
      end
   endtask

   // expected syndrome for the current mode, zero when nothing traps
   function [5:0] exp_ec(input [1:0] l, input [3:0] k, input [3:0] r, input h, input p);
      reg [5:0] e;
      begin
         e = 6'h00;
         if (l == 2'h1 && h && nv && !rd) begin
            if ((k == `NVTR_OP_RD || k == `NVTR_OP_WR) && r != 4'h0 && r != `NVTR_R_SP_HYP
               && r < 4'hb) e = `NVTR_EC_SYSREG;
            if (k == `NVTR_OP_AT_HYP || k == `NVTR_OP_AT_KERN) e = `NVTR_EC_SYSREG;
            if (k == `NVTR_OP_SMC && smc_trap_ctrl) e = `NVTR_EC_SMC;
            if (k >= `NVTR_OP_ERET) e = `NVTR_EC_ERET;
         end
         if (e == 6'h00 && p && !pa) e = `NVTR_EC_PAUTH;
         exp_ec = e;
      end
   endfunction

   // issue one op and compare the registered answer
   task op(input [1:0] l, input [3:0] k, input [3:0] r, input h, input p);
      reg [5:0] e;
      reg       rv;
      reg [1:0] lv;
      begin
         e = exp_ec(l, k, r, h, p);
         lv = (nv && !rd && l == 2'h1 && h) ? `NVTR_FAKE_LEVEL : l;
         rv = l == 2'h1 && nv && rd && (k == `NVTR_OP_RD || k == `NVTR_OP_WR)
            && r >= 4'h7 && r <= 4'ha;
         @(posedge pclk);
         op_valid <= 1'b1;
         op_level <= l;
         op_kind <= k;
         op_reg <= r;
         hyp_en <= h;
         pauth_req <= p;
         @(posedge pclk);
         op_valid <= 1'b0;
         #1;
         check(trap_valid, e != 6'h00);
         check(trap_ec, e);
         check(redir_valid, rv);
         if (rv) check(redir_reg, r + 4'h4);
         check(level_valid, k == `NVTR_OP_CUR_RD);
         if (k == `NVTR_OP_CUR_RD) check(level_data, lv);
      end
   endtask

   task results;
      begin
         $display("counts: checked=%0d failures=%0d", checked, failures);
         if (failures == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   // clock, 100 ns period
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // watchdog over the whole run
   initial begin
      #2000000;
      failures = failures + 1;
      results;
   end

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, op_valid, hyp_en, pauth_req} = 7'h00;
      {paddr, pwdata, op_level, op_kind, op_reg} = 50'h0;
      {nv, rd, smc_trap_ctrl, pa, failures, checked} = 0;
      seed = $urandom(78);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`NVTR_CTRL_OFF, 32'h0000_0000);
      rd_chk(`NVTR_CFG_OFF, 32'h0000_0000);
      rd_chk(`NVTR_STAT_OFF, 32'h0000_0000);
      rd_chk(`NVTR_EN_OFF, 32'h0000_0000);
      rd_chk(`NVTR_INFO_OFF, 32'h0000_0003);
      rd_chk(8'h20, 32'h0000_0000);
      check(err, 1'b1);
      $display("test reset and map done");
      // every mode: readback, corner ops, then random ops
      for (m = 0; m < 4; m = m + 1) begin
         nv = m[1];
         rd = m[0];
         smc_trap_ctrl = $urandom % 2;
         pa = $urandom % 2;
         apb(1'b1, `NVTR_CTRL_OFF, {29'h0, pa, smc_trap_ctrl, rd});
         apb(1'b1, `NVTR_CFG_OFF, {21'h0, nv, 10'h000});
         rd_chk(`NVTR_CFG_OFF, {21'h0, nv, 10'h000});
         rd_chk(`NVTR_CTRL_OFF, {29'h0, pa, smc_trap_ctrl, rd});
         check(nv_tlb, nv);
         op(2'h1, `NVTR_OP_RD, `NVTR_R_SP_HYP, 1'b1, 1'b0);
         op(2'h1, `NVTR_OP_WR, `NVTR_R_FA_HYP, 1'b1, 1'b0);
         op(2'h1, `NVTR_OP_CUR_RD, `NVTR_R_OTHER, 1'b1, 1'b0);
         op(2'h1, `NVTR_OP_SMC, `NVTR_R_OTHER, 1'b1, 1'b0);
         for (i = 0; i < 40; i = i + 1) begin
            rk = $urandom % 10;
            rl = $urandom % 4;
            rh = $urandom % 2;
            op(rl, rk, $urandom % 15, rh, rk >= `NVTR_OP_ERETAA && rl == 2'h1 && rh
               && ($urandom % 2));
         end
         $display("test mode %0d done", m);
      end
      // authenticated return caught by both traps
      pa = 1'b0;
      nv = 1'b1;
      rd = 1'b0;
      apb(1'b1, `NVTR_CTRL_OFF, 32'h0000_0000);
      apb(1'b1, `NVTR_CFG_OFF, 32'h0000_0400);
      apb(1'b1, `NVTR_CLR_OFF, 32'h0000_0007);
      apb(1'b1, `NVTR_CNT_OFF, 32'h0000_0000);
      op(2'h1, `NVTR_OP_ERETAA, `NVTR_R_OTHER, 1'b1, 1'b1);
      rd_chk(`NVTR_STAT_OFF, 32'h0000_0005);
      rd_chk(`NVTR_LAST_OFF, 32'h0000_005a);
      rd_chk(`NVTR_CNT_OFF, 32'h0000_0001);
      $display("test priority done");
      // interrupt raise, mask, clear
      apb(1'b1, `NVTR_CLR_OFF, 32'h0000_0007);
      apb(1'b1, `NVTR_EN_OFF, 32'h0000_0001);
      op(2'h1, `NVTR_OP_AT_HYP, `NVTR_R_OTHER, 1'b1, 1'b0);
      @(posedge pclk);
      #1 check(irq, 1'b1);
      apb(1'b1, `NVTR_EN_OFF, 32'h0000_0000);
      @(posedge pclk);
      #1 check(irq, 1'b0);
      rd_chk(`NVTR_STAT_OFF, 32'h0000_0001);
      apb(1'b1, `NVTR_EN_OFF, 32'h0000_0001);
      @(posedge pclk);
      #1 check(irq, 1'b1);
      apb(1'b1, `NVTR_CLR_OFF, 32'h0000_0001);
      @(posedge pclk);
      #1 check(irq, 1'b0);
      rd_chk(`NVTR_STAT_OFF, 32'h0000_0000);
      rd_chk(`NVTR_CLR_OFF, 32'h0000_0000);
      $display("test interrupt done");
      results;
   end
endmodule // nested_virt_trap_redirect_bench
